/* gated_timer_cfg.svh */
// How it works
// - special event trigger clears whole counter
// - trigger clear never sets overflow flag
// - compare pair acts as counter period
// - byte write beats a simultaneous trigger
// - comparator output resampled on increment clock
// - external mode needs falling edge first
// - bit 7 picks gate polarity, any source
// - bit 6 gates counting only while on
// - bits 5-4 select prescale 1,2,4,8
// - bit 3 LP oscillator only without clkout
// - bit 2 bypasses external sync, external only
// - bit 1 picks pin or internal clock
// - bit 0 starts and stops counting
// - gate source chosen, effective only when enabled
// - count read and written as two bytes
// - rollover FFFF to 0000 sets overflow flag
// - byte write clears hidden prescale counter
`ifndef GATED_TIMER_CFG_SVH
`define GATED_TIMER_CFG_SVH

`define ADDR_W             3
`define OFS_CONTROL        3'h0
`define OFS_COUNT_LOW      3'h1
`define OFS_COUNT_HIGH     3'h2
`define OFS_AUX_CONTROL    3'h3
`define OFS_IRQ_ENABLE     3'h4
`define OFS_IRQ_FLAGS      3'h5

`define CTL_GATE_POL       7
`define CTL_GATE_EN        6
`define CTL_PRESCALE_HI    5
`define CTL_PRESCALE_LO    4
`define CTL_LP_OSC_EN      3
`define CTL_SYNC_BYPASS    2
`define CTL_CLK_SRC        1
`define CTL_TIMER_ON       0

`define AUX_COMP2_OUT      6
`define AUX_FAST_CLK       4
`define AUX_GATE_SRC       1
`define AUX_COMP_SYNC      0
`define AUX_WR_MASK        8'h1F

`define IRQ_OVERFLOW       0
`define IRQ_SPECIAL_EVT    5
`define IRQ_MASK           8'h21

`define RST_CONTROL        8'h00
`define RST_AUX_CONTROL    8'h02
`define RST_IRQ_ENABLE     8'h00
`define RST_IRQ_FLAGS      8'h00
`define RST_COUNT          16'h0000
`define COUNT_MAX          16'hFFFF

`define INT_DIV_LAST       2'h3

`endif

/* gated_timer_pkg.sv */
package gated_timer_pkg;
   typedef logic [7:0]  byte_t;
   typedef logic [15:0] count_t;
   typedef logic [2:0]  presc_t;
   // increment clock origin, gray along fosc4 -> fosc -> pin -> lp
   typedef enum logic [1:0] {
      SRC_FOSC4 = 2'b00,
      SRC_FOSC  = 2'b01,
      SRC_PIN   = 2'b11,
      SRC_LP    = 2'b10
   } clk_src_t;
endpackage

/* timer_clk_if.sv */
`timescale 1ns/1ps
interface timer_clk_if;
   logic raw_clk;    // selected external clock level
   logic bypass;     // skip the two-stage synchroniser
   logic ext_mode;   // external source counting active
   logic tick;       // one-cycle counting edge
   modport ctrl (output raw_clk, output bypass, output ext_mode, input tick);
   modport edge_det (input raw_clk, input bypass, input ext_mode, output tick);
endinterface

/* timer_edge_detect.sv */
`timescale 1ns/1ps
`include "gated_timer_cfg.svh"
module timer_edge_detect (
   input  wire logic     i_clk_sys,  // system clock
   input  wire logic     i_rst,      // synchronous reset
   timer_clk_if.edge_det clk_if      // external clock path
);
   import gated_timer_pkg::*;

   logic sync1_reg;
   logic sync2_reg;
   logic raw_reg;
   logic prev_reg;
   logic armed_reg;
   logic armed_next;
   wire  level;
   wire  rise;
   wire  fall;

   assign level = clk_if.bypass ? raw_reg : sync2_reg;
   assign rise  = level & ~prev_reg;
   assign fall  = ~level & prev_reg;
   assign armed_next = clk_if.ext_mode & (armed_reg | fall);
   assign clk_if.tick = clk_if.ext_mode & armed_reg & rise;

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         raw_reg   <= 1'b0;
         prev_reg  <= 1'b0;
         armed_reg <= 1'b0;
      end else begin
         sync1_reg <= clk_if.raw_clk;
         sync2_reg <= sync1_reg;
         raw_reg   <= clk_if.raw_clk;
         prev_reg  <= level;
         armed_reg <= armed_next;
      end
   end

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);

   no_edge_unarmed_a: assert property (
      clk_if.ext_mode && !armed_reg && !fall |=> !clk_if.tick
   ) else $error("counting edge without prior falling edge");
endmodule // timer_edge_detect

/* gated_timer.sv */
`timescale 1ns/1ps
`include "gated_timer_cfg.svh"
module gated_timer (
   input  wire logic                  i_clk_sys,          // 100 MHz system clock
   input  wire logic                  i_rst,              // synchronous reset
   input  wire logic [`ADDR_W-1:0]    i_addr,             // register address
   input  wire gated_timer_pkg::byte_t i_wdata,           // write data
   input  wire logic                  i_wr,               // write strobe
   input  wire logic                  i_rd,               // read strobe
   input  wire logic                  i_ext_clock_pin,    // external count clock
   input  wire logic                  i_lp_osc_clk,       // LP crystal oscillator level
   input  wire logic                  i_internal_osc,     // internal osc without clkout
   input  wire logic                  i_gate_pin,         // gate pin
   input  wire logic                  i_comparator_two_output, // raw comparator out
   input  wire logic                  i_special_event,    // trigger pulse from compare
   output gated_timer_pkg::byte_t     o_rdata,            // read data, next cycle
   output logic                       o_irq,              // level interrupt
   output gated_timer_pkg::count_t    o_count,            // counter to compare unit
   output logic                       o_comp_synced,      // comparator on timer clock
   output logic                       o_lp_osc_enable     // LP oscillator run request
);
   import gated_timer_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // registers
   byte_t    ctrl_reg;
   byte_t    aux_reg;
   byte_t    irq_en_reg;
   byte_t    irq_flag_reg;
   byte_t    irq_flag_next;
   count_t   count_reg;
   count_t   count_next;
   presc_t   pre_reg;
   presc_t   pre_next;
   logic [1:0] div_reg;
   byte_t    rdata_reg;
   logic     irq_reg;
   logic     comp_sync_reg;
   logic     lp_en_reg;
   logic     gate_s1_reg;
   logic     gate_s2_reg;

   timer_clk_if clk_if ();

   timer_edge_detect u_edge (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst),
      .clk_if    (clk_if)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // helpers
   function automatic presc_t presc_last(input logic [1:0] sel);
      presc_last = presc_t'((4'h1 << sel) - 4'h1);
   endfunction

   function automatic logic hit(input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] o);
      hit = (a == o);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // decode
   wire       gate_pol    = ctrl_reg[`CTL_GATE_POL];
   wire       gate_en     = ctrl_reg[`CTL_GATE_EN];
   wire [1:0] presc_sel   = ctrl_reg[`CTL_PRESCALE_HI:`CTL_PRESCALE_LO];
   wire       lp_bit      = ctrl_reg[`CTL_LP_OSC_EN];
   wire       sync_bypass = ctrl_reg[`CTL_SYNC_BYPASS];
   wire       ext_src     = ctrl_reg[`CTL_CLK_SRC];
   wire       timer_on    = ctrl_reg[`CTL_TIMER_ON];
   wire       fast_clk    = aux_reg[`AUX_FAST_CLK];
   wire       gate_src    = aux_reg[`AUX_GATE_SRC];
   wire       comp_sync   = aux_reg[`AUX_COMP_SYNC];

   wire wr_ctrl  = i_wr & hit(i_addr, `OFS_CONTROL);
   wire wr_low   = i_wr & hit(i_addr, `OFS_COUNT_LOW);
   wire wr_high  = i_wr & hit(i_addr, `OFS_COUNT_HIGH);
   wire wr_aux   = i_wr & hit(i_addr, `OFS_AUX_CONTROL);
   wire wr_ien   = i_wr & hit(i_addr, `OFS_IRQ_ENABLE);
   wire wr_iflag = i_wr & hit(i_addr, `OFS_IRQ_FLAGS);
   wire cnt_wr   = wr_low | wr_high;

   ////////////////////////////////////////////////////////////////////////////////
   // clock source selection
   wire      lp_active = lp_bit & i_internal_osc;
   clk_src_t src;
   assign src = ext_src ? (lp_active ? SRC_LP : SRC_PIN)
                        : (fast_clk ? SRC_FOSC : SRC_FOSC4);

   assign clk_if.raw_clk  = (src == SRC_LP) ? i_lp_osc_clk : i_ext_clock_pin;
   assign clk_if.bypass   = sync_bypass & ext_src;
   assign clk_if.ext_mode = ext_src & timer_on;

   wire int_tick = (src == SRC_FOSC) | (div_reg == `INT_DIV_LAST);
   wire src_tick = ext_src ? clk_if.tick : int_tick;

   ////////////////////////////////////////////////////////////////////////////////
   // gate
   wire comp_level  = comp_sync ? comp_sync_reg : i_comparator_two_output;
   wire gate_level  = gate_src ? comp_level : gate_s2_reg;
   wire gate_active = gate_pol ? gate_level : ~gate_level;
   wire gate_ok     = ~gate_en | gate_active;
   wire run         = timer_on & gate_ok;

   ////////////////////////////////////////////////////////////////////////////////
   // prescaler and counter
   wire pre_done = src_tick & (pre_reg == presc_last(presc_sel));
   wire inc      = run & pre_done;
   wire sevt_clr = i_special_event & ~cnt_wr;
   wire wrap     = inc & ~cnt_wr & ~i_special_event & (count_reg == `COUNT_MAX);

   always_comb begin
      pre_next = pre_reg;
      if (cnt_wr) begin
         pre_next = '0;
      end else if (run & src_tick) begin
         pre_next = pre_done ? '0 : presc_t'(pre_reg + 3'h1);
      end
   end

   // compare match drives the trigger, so the compare pair sets the period
   always_comb begin
      count_next = count_reg;
      if (cnt_wr) begin
         if (wr_low) begin
            count_next[7:0] = i_wdata;
         end
         if (wr_high) begin
            count_next[15:8] = i_wdata;
         end
      end else if (i_special_event) begin
         count_next = `RST_COUNT;
      end else if (inc) begin
         count_next = count_t'(count_reg + 16'h0001);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // interrupt flags, set beats write-one clear
   wire [7:0] flag_set = {2'b00, i_special_event, 4'b0000, wrap};
   wire [7:0] flag_clr = wr_iflag ? (i_wdata & `IRQ_MASK) : 8'h00;
   assign irq_flag_next = (irq_flag_reg & ~flag_clr) | flag_set;
   // next mask too, so the pin never lags a mask write
   wire [7:0] ien_next = wr_ien ? (i_wdata & `IRQ_MASK) : irq_en_reg;
   wire irq_next = |(irq_flag_next & ien_next);

   ////////////////////////////////////////////////////////////////////////////////
   // read mux
   wire [7:0] aux_view = {1'b0, i_comparator_two_output, aux_reg[5:0]};
   wire [7:0] rd_mux =
      hit(i_addr, `OFS_CONTROL)     ? ctrl_reg        :
      hit(i_addr, `OFS_COUNT_LOW)   ? count_reg[7:0]  :
      hit(i_addr, `OFS_COUNT_HIGH)  ? count_reg[15:8] :
      hit(i_addr, `OFS_AUX_CONTROL) ? aux_view        :
      hit(i_addr, `OFS_IRQ_ENABLE)  ? irq_en_reg      :
      hit(i_addr, `OFS_IRQ_FLAGS)   ? irq_flag_reg    : 8'h00;
   wire [7:0] rdata_next = i_rd ? rd_mux : 8'h00;

   ////////////////////////////////////////////////////////////////////////////////
   // software registers
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         ctrl_reg   <= `RST_CONTROL;
         aux_reg    <= `RST_AUX_CONTROL;
         irq_en_reg <= `RST_IRQ_ENABLE;
      end else begin
         if (wr_ctrl) begin
            ctrl_reg <= i_wdata;
         end
         if (wr_aux) begin
            aux_reg <= i_wdata & `AUX_WR_MASK;
         end
         if (wr_ien) begin
            irq_en_reg <= i_wdata & `IRQ_MASK;
         end
      end
   end

   // timer state
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         count_reg    <= `RST_COUNT;
         pre_reg      <= '0;
         div_reg      <= '0;
         irq_flag_reg <= `RST_IRQ_FLAGS;
      end else begin
         count_reg    <= count_next;
         pre_reg      <= pre_next;
         div_reg      <= 2'(div_reg + 2'h1);
         irq_flag_reg <= irq_flag_next;
      end
   end

   // output and sampling flops
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         rdata_reg     <= 8'h00;
         irq_reg       <= 1'b0;
         comp_sync_reg <= 1'b0;
         lp_en_reg     <= 1'b0;
         gate_s1_reg   <= 1'b0;
         gate_s2_reg   <= 1'b0;
      end else begin
         rdata_reg   <= rdata_next;
         irq_reg     <= irq_next;
         lp_en_reg   <= lp_active;
         gate_s1_reg <= i_gate_pin;
         gate_s2_reg <= gate_s1_reg;
         if (src_tick) begin
            comp_sync_reg <= i_comparator_two_output;
         end
      end
   end

   assign o_rdata         = rdata_reg;
   assign o_irq           = irq_reg;
   assign o_count         = count_reg;
   assign o_comp_synced   = comp_sync_reg;
   assign o_lp_osc_enable = lp_en_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);

   sequence s_trigger_alone;
      i_special_event && !cnt_wr;
   endsequence

   sequence s_counter_cleared;
      count_reg == 16'h0000;
   endsequence

   property p_trigger_clears;
      s_trigger_alone |=> s_counter_cleared;
   endproperty

   special_event_clear_a: assert property (p_trigger_clears)
      else $error("trigger did not clear counter");

   trigger_no_overflow_a: assert property (
      s_trigger_alone ##0 !irq_flag_reg[0] |=> !irq_flag_reg[0]
   ) else $error("trigger clear set overflow flag");

   write_beats_trigger_a: assert property (
      i_special_event && wr_low && !wr_high |=> count_reg[7:0] == $past(i_wdata)
   ) else $error("trigger overrode low byte write");

   rollover_flag_a: assert property (
      wrap |=> count_reg == 16'h0000 && irq_flag_reg[0] ##1 (irq_flag_reg[0] || $past(wr_iflag))
   ) else $error("rollover missed or flag lost");

   prescale_cleared_a: assert property (
      cnt_wr |=> pre_reg == 3'h0
   ) else $error("byte write left prescaler dirty");

   stopped_holds_a: assert property (
      !timer_on && !cnt_wr && !i_special_event |=> count_reg == $past(count_reg)
   ) else $error("counter moved while stopped");

   gate_blocks_a: assert property (
      timer_on && gate_en && !gate_active && !cnt_wr && !i_special_event
         |=> count_reg == $past(count_reg)
   ) else $error("counter moved with gate closed");

   prescale_ratio_a: assert property (
      inc && presc_sel == 2'b11 |-> pre_reg == 3'h7
   ) else $error("1:8 prescale not eight ticks");

   fosc4_rate_a: assert property (
      timer_on && !ext_src && !fast_clk && !gate_en && presc_sel == 2'b00 && inc
         |=> !inc [*3]
   ) else $error("internal quarter clock too fast");

   irq_level_a: assert property (
      o_irq == |(irq_flag_reg & irq_en_reg)
   ) else $error("interrupt level differs from masked flags");

   sequence s_fast_free_run;
      timer_on && !ext_src && fast_clk && !gate_en && presc_sel == 2'b00 && pre_reg == 3'h0
         && !cnt_wr && !i_special_event;
   endsequence

   fast_rate_a: assert property (
      s_fast_free_run |=> count_reg == count_t'($past(count_reg) + 16'h0001)
   ) else $error("full-rate internal clock missed an increment");

   write_high_beats_a: assert property (
      i_special_event && wr_high && !wr_low
         |=> count_reg[15:8] == $past(i_wdata) && count_reg[7:0] == $past(count_reg[7:0])
   ) else $error("trigger overrode high byte write");

   comp_sample_a: assert property (
      src_tick |=> o_comp_synced == $past(i_comparator_two_output)
   ) else $error("comparator not sampled on timer tick");

   lp_enable_a: assert property (
      1'b1 |=> o_lp_osc_enable == $past(lp_bit && i_internal_osc)
   ) else $error("low-power oscillator request wrong");

   read_idle_zero_a: assert property (
      !i_rd |=> o_rdata == 8'h00
   ) else $error("read data outside read cycle");
endmodule // gated_timer

/* compare_partner.sv */
`timescale 1ns/1ps
module compare_partner (
   input  wire logic                    i_clk_sys,  // system clock
   input  wire logic                    i_rst,      // synchronous reset
   input  wire gated_timer_pkg::count_t i_count,    // timer value
   input  wire logic                    i_en,       // trigger on match
   input  wire gated_timer_pkg::count_t i_period,   // compare value pair
   input  wire logic                    i_fire,     // forced trigger
   output logic                         o_event     // special event pulse
);
   import gated_timer_pkg::*;
   logic hit;
   logic fire_reg;
   // match is seen at once, so the clear lands before the count passes the period
   assign hit     = i_en && (i_count == i_period);
   assign o_event = hit || fire_reg;
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         fire_reg <= 1'b0;
      end else begin
         fire_reg <= i_fire;
      end
   end
endmodule // compare_partner

/* test_gated_timer_control_and_event_clear.sv */
`timescale 1ns/1ps
`include "gated_timer_cfg.svh"
module test_gated_timer_control_and_event_clear;
   import gated_timer_pkg::*;
   logic       clk_sys = 1'b0, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0;
   logic       ext_pin = 1'b1, int_osc = 1'b0, gate_pin = 1'b0, comp = 1'b0;
   logic       fire = 1'b0, pen = 1'b0, evt, irq, lp_en;
   logic       lp_clk = 1'b1, comp_syn;
   logic [2:0] addr = 3'h0;
   byte_t      wdata = 8'h00, b, rdata;
   count_t     c, count;
   count_t     period = 16'h0010;
   int         err_total = 0, checks = 0, sh;

   always #5 clk_sys = ~clk_sys;

   gated_timer u_dut (.i_clk_sys(clk_sys), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr_s), .i_rd(rd_s), .i_ext_clock_pin(ext_pin), .i_lp_osc_clk(lp_clk),
      .i_internal_osc(int_osc), .i_gate_pin(gate_pin), .i_comparator_two_output(comp),
      .i_special_event(evt), .o_rdata(rdata), .o_irq(irq), .o_count(count),
      .o_comp_synced(comp_syn), .o_lp_osc_enable(lp_en));
   compare_partner u_partner (.i_clk_sys(clk_sys), .i_rst(rst), .i_count(count),
      .i_en(pen), .i_period(period), .i_fire(fire), .o_event(evt));

   ////////////////////////////////////////////////////////////////////////
   task automatic give_verdict;
      if (err_total == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk_rng(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
      checks++;
      if (!((got >= lo) === 1'b1 && (got <= hi) === 1'b1)) begin
         err_total++;
         $display("mismatch t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      end
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      chk_rng(got, exp, exp);
   endtask
   task automatic wr(input logic [2:0] a, input byte_t d);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk_sys);
      wr_s <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic rd(input logic [2:0] a, output byte_t d);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk_sys);
      rd_s <= 1'b0;
      #1;
      d = rdata;
      @(posedge clk_sys);
   endtask
   task automatic rd_cnt(output count_t v);
      byte_t lo, hi;
      rd(3'h1, lo);
      rd(3'h2, hi);
      v = {hi, lo};
   endtask
   // clear count, run n cycles with ctrl, stop, read count back
   task automatic run_cnt(input byte_t ctl, input byte_t aux, input int n, output count_t v);
      wr(3'h3, aux);
      wr(3'h2, 8'h00);
      wr(3'h1, 8'h00);
      wr(3'h0, ctl);
      repeat (n) @(posedge clk_sys);
      wr(3'h0, ctl & 8'hFE);
      rd_cnt(v);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      #100000;
      err_total++;
      give_verdict();
   end

   initial begin
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      for (int i = 0; i < 7; i++) begin
         rd(i[2:0], b);
         chk(b, (i == 3) ? 16'h0002 : 16'h0000);
      end
      wr(3'h1, 8'hA5);
      wr(3'h2, 8'h3C);
      rd_cnt(c);
      chk(c, 16'h3CA5);
      wr(3'h1, 8'h11);
      rd_cnt(c);
      chk(c, 16'h3C11);
      for (int s = 0; s < 5; s++) begin
         sh = (s < 4) ? s : 2;
         run_cnt({2'b00, s[1:0], 4'h1}, (s < 4) ? 8'h10 : 8'h00, 64, c);
         chk_rng(c, (16'h0040 >> sh) - 1, (16'h0044 >> sh) + 1);
      end
      run_cnt(8'h40, 8'h10, 16, c);
      chk(c, 16'h0000);
      for (int i = 0; i < 8; i++) begin
         gate_pin <= i[0];
         run_cnt({i[2], i[1], 6'h01}, 8'h10, 16, c);
         if (!i[1] || i[2] == i[0]) chk_rng(c, 16'h000D, 16'h0014);
         else chk(c, 16'h0000);
      end
      gate_pin <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         comp <= k[0];
         run_cnt(8'hC1, 8'h13, 16, c);
         chk_rng(c, k ? 16'h000D : 16'h0000, k ? 16'h0014 : 16'h0000);
         chk(comp_syn, k[0]);
      end
      // pin starts high for k 0-1 and low for k 2-3: a first rise without a prior fall must not count
      for (int k = 0; k < 4; k++) begin
         ext_pin <= ~k[1];
         wr(3'h2, 8'h00);
         wr(3'h1, 8'h00);
         wr(3'h0, k[0] ? 8'h07 : 8'h03);
         repeat (10) begin
            ext_pin <= ~ext_pin;
            repeat (6) @(posedge clk_sys);
         end
         repeat (8) @(posedge clk_sys);
         wr(3'h0, 8'h00);
         rd_cnt(c);
         chk(c, k[1] ? 16'h0004 : 16'h0005);
      end
      wr(3'h4, 8'h01);
      wr(3'h3, 8'h10);
      wr(3'h2, 8'hFF);
      wr(3'h1, 8'hFD);
      wr(3'h0, 8'h01);
      repeat (8) @(posedge clk_sys);
      wr(3'h0, 8'h00);
      rd(3'h5, b);
      chk(b, 16'h0001);
      chk(irq, 1'b1);
      rd(3'h2, b);
      chk(b, 16'h0000);
      wr(3'h4, 8'h00);
      chk(irq, 1'b0);
      wr(3'h4, 8'h21);
      wr(3'h5, 8'h01);
      rd(3'h5, b);
      chk(b, 16'h0000);
      chk(irq, 1'b0);
      pen <= 1'b1;
      run_cnt(8'h01, 8'h10, 60, c);
      chk_rng(c, 16'h0000, 16'h0010);
      rd(3'h5, b);
      chk(b, 16'h0020);
      chk(irq, 1'b1);
      wr(3'h5, 8'h20);
      pen <= 1'b0;
      for (int k = 0; k < 2; k++) begin
         fire <= 1'b1;
         @(posedge clk_sys);
         fire <= 1'b0;
         wr(k ? 3'h1 : 3'h2, k ? 8'h55 : 8'h12);
      end
      rd_cnt(c);
      chk(c, 16'h1255);
      fire <= 1'b1;
      @(posedge clk_sys);
      fire <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rd_cnt(c);
      chk(c, 16'h0000);
      rd(3'h5, b);
      chk(b, 16'h0020);
      int_osc <= 1'b1;
      wr(3'h2, 8'h00);
      wr(3'h1, 8'h00);
      wr(3'h0, 8'h0B);
      @(negedge clk_sys);
      chk(lp_en, 1'b1);
      @(posedge clk_sys);
      repeat (10) begin
         lp_clk <= ~lp_clk;
         repeat (6) @(posedge clk_sys);
      end
      repeat (8) @(posedge clk_sys);
      wr(3'h0, 8'h00);
      rd_cnt(c);
      chk(c, 16'h0005);
      int_osc <= 1'b0;
      wr(3'h0, 8'h08);
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      chk(lp_en, 1'b0);
      give_verdict();
   end
endmodule // test_gated_timer_control_and_event_clear
